// >>> logic/qsf_consts.svh
`ifndef QSF_CONSTS_SVH
`define QSF_CONSTS_SVH

`define QSF_OP_READ   8'h03
`define QSF_OP_FAST   8'h0B
`define QSF_OP_DUAL   8'hBB
`define QSF_OP_QUAD   8'hEB
`define QSF_OP_PROG   8'h02
`define QSF_OP_SECT   8'h20
`define QSF_OP_BLK32  8'h52
`define QSF_OP_BLK64  8'hD8
`define QSF_OP_CHIP1  8'hC7
`define QSF_OP_CHIP2  8'h60
`define QSF_OP_RDSR   8'h05
`define QSF_OP_SUSP   8'h75
`define QSF_OP_WREN   8'h06
`define QSF_OP_WRDI   8'h04

`define QSF_OPC_BITS   6'h08
`define QSF_ADDR_BITS  6'h18
`define QSF_BYTE_BITS  6'h08
`define QSF_DUMMY_FAST 6'h08
`define QSF_DUMMY_DUAL 6'h04
`define QSF_DUMMY_QUAD 6'h06
`define QSF_PAGE_BYTES 9'h100

`endif

// >>> logic/qsf_pkg.sv
`include "qsf_consts.svh"
`default_nettype none
package qsf_pkg;

	typedef logic [7:0]  qsf_byte_t;
	typedef logic [23:0] qsf_addr_t;

	typedef enum {DS_OPC, DS_ADDR, DS_DUMMY, DS_READ, DS_WRITE,
		DS_IGNORE} qsf_dst_t;

	typedef enum {HS_IDLE, HS_SEL, HS_OPC, HS_ADDR, HS_DUMMY, HS_DATA,
		HS_DESEL} qsf_hst_t;

	typedef struct packed {
		qsf_dst_t   st;
		logic [5:0] cnt;
		qsf_addr_t  sh;
		qsf_byte_t  op;
		qsf_byte_t  tx;
		logic [8:0] wbytes;
		logic       cmd_tgl;
		qsf_byte_t  cmd_op;
		qsf_addr_t  cmd_addr;
		logic       wr_tgl;
		qsf_byte_t  wr_data;
	} qsf_dlink_t;

	typedef struct packed {
		logic [3:0] d_o;
		logic [3:0] d_oe;
	} qsf_dout_t;

	typedef struct packed {
		logic      armed;
		logic      cmd_seen;
		logic      wr_seen;
		logic      cmd_valid;
		qsf_byte_t cmd_op;
		qsf_addr_t cmd_addr;
		logic      wr_valid;
		qsf_byte_t wr_data;
		logic      standby;
		logic      wp_asserted;
	} qsf_dsys_t;

	typedef struct packed {
		qsf_hst_t   st;
		logic [7:0] div;
		logic       sclk;
		logic       cs_n;
		logic       hold_n;
		qsf_byte_t  op;
		qsf_addr_t  addr;
		logic       wr;
		logic [8:0] len;
		logic [8:0] bytes;
		logic [5:0] cnt;
		logic [31:0] tx;
		qsf_byte_t  rx;
		logic [3:0] io_o;
		logic [3:0] io_oe;
		logic       ready;
		logic       wr_take;
		logic       rd_valid;
		qsf_byte_t  rd_data;
		logic       done;
	} qsf_host_t;

	function automatic logic [2:0] qsf_lanes(input qsf_byte_t op);
		case (op)
			`QSF_OP_DUAL: return 3'h2;
			`QSF_OP_QUAD: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction

	function automatic logic [5:0] qsf_dummy(input qsf_byte_t op);
		case (op)
			`QSF_OP_FAST: return `QSF_DUMMY_FAST;
			`QSF_OP_DUAL: return `QSF_DUMMY_DUAL;
			`QSF_OP_QUAD: return `QSF_DUMMY_QUAD;
			default: return 6'h00;
		endcase
	endfunction

	function automatic logic qsf_is_erase(input qsf_byte_t op);
		return op == `QSF_OP_SECT || op == `QSF_OP_BLK32 ||
			op == `QSF_OP_BLK64;
	endfunction

	function automatic logic qsf_has_addr(input qsf_byte_t op);
		return qsf_is_erase(op) || op == `QSF_OP_READ ||
			op == `QSF_OP_FAST || op == `QSF_OP_DUAL ||
			op == `QSF_OP_QUAD || op == `QSF_OP_PROG;
	endfunction

	function automatic logic qsf_bare_cmd(input qsf_byte_t op);
		return op == `QSF_OP_WREN || op == `QSF_OP_WRDI ||
			op == `QSF_OP_CHIP1 || op == `QSF_OP_CHIP2 ||
			op == `QSF_OP_SUSP;
	endfunction

endpackage
`default_nettype wire

// >>> logic/qsf_if.sv
`default_nettype none
interface qsf_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] h_o;
	logic [3:0] h_oe;
	logic [3:0] d_o;
	logic [3:0] d_oe;
	logic [3:0] line;

	// undriven lines float up, as the pins carry pull-ups
	assign line = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe);

	modport host (
		output cs_n,
		output sclk,
		output h_o,
		output h_oe,
		input  line
	);
	modport dev (
		input  cs_n,
		input  sclk,
		input  line,
		output d_o,
		output d_oe
	);
endinterface
`default_nettype wire

// >>> logic/qsf_sync.sv
`default_nettype none
module qsf_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= '0;
			o_q  <= '0;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule
`default_nettype wire

// >>> logic/qsf_dev.sv
// Operation
// - chip select high: deselected, output released
// - standby only when no internal cycle runs
// - first instruction needs a chip select fall
// - inputs captured on rising clock edge
// - outputs change on falling clock edge
// - only clock modes 0 and 3
// - opcode BB uses two bidirectional lines
// - opcode EB uses four bidirectional lines
// - quad instructions need quad lines enable
// - write protect low guards status, unless quad
// - hold: output released, clock and data ignored
// - quad lines enable disables hold
// - hold starts on hold fall, clock low
// - hold ends on hold rise, count kept
// - hold lasts while hold pin low
// - chip select rise in hold resets interface
// - page program takes at most 256 bytes
// - erase by sector, 32KB, 64KB, chip
// - busy: only status read and suspend accepted
`include "qsf_consts.svh"
`default_nettype none
module qsf_dev (
	qsf_if.dev                   link,
	input  wire logic            i_clk_sys,
	input  wire logic            i_rst_n,
	input  wire logic            i_quad_lines_enable,
	input  wire logic            i_busy,
	input  wire qsf_pkg::qsf_byte_t i_status,
	input  wire qsf_pkg::qsf_byte_t i_rd_data,
	output logic                 o_cmd_valid,
	output qsf_pkg::qsf_byte_t   o_cmd_op,
	output qsf_pkg::qsf_addr_t   o_cmd_addr,
	output logic                 o_wr_valid,
	output qsf_pkg::qsf_byte_t   o_wr_data,
	output logic                 o_standby,
	output logic                 o_wp_asserted
);
	import qsf_pkg::*;

	qsf_dlink_t l;
	qsf_dlink_t next_l;
	qsf_dout_t  o;
	qsf_dout_t  next_o;
	qsf_dsys_t  s;
	qsf_dsys_t  next_s;

	logic [17:0] lsync;
	logic        quad_en_l;
	logic        busy_l;
	qsf_byte_t   status_l;
	qsf_byte_t   rd_l;
	logic [3:0]  ssync;
	logic        frame_rst_n;
	logic        out_rst_n;
	logic        in_frame;
	logic        hold_on;

	qsf_dst_t    st;
	logic [5:0]  cnt;
	qsf_addr_t   sh;
	logic [2:0]  w;
	logic [3:0]  bits;
	qsf_addr_t   nsh;
	logic [5:0]  ncnt;
	qsf_byte_t   op;

	////////////////////////////////////////////////////////////////////////
	// crossings; status and read data are quasi-static, held by the core
	qsf_sync #(
		.W(18)
	) u_lsync (
		.i_clk   (link.sclk),
		.i_rst_n (i_rst_n),
		.i_d     ({i_quad_lines_enable, i_busy, i_status, i_rd_data}),
		.o_q     (lsync)
	);
	assign {quad_en_l, busy_l, status_l, rd_l} = lsync;

	qsf_sync #(
		.W(4)
	) u_ssync (
		.i_clk   (i_clk_sys),
		.i_rst_n (i_rst_n),
		.i_d     ({link.cs_n, l.cmd_tgl, l.wr_tgl, link.line[2]}),
		.o_q     (ssync)
	);

	////////////////////////////////////////////////////////////////////////
	// frame marker: cleared while deselected, so a new frame restarts
	assign frame_rst_n = i_rst_n & s.armed & ~link.cs_n;
	assign hold_on     = ~link.line[3] & ~quad_en_l;
	assign out_rst_n   = frame_rst_n & ~hold_on;

	always_ff @(posedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// rising-edge capture; edge based, so modes 0 and 3 behave alike
	always_comb begin
		next_l = l;
		op     = l.op;
		st     = in_frame ? l.st : DS_OPC;
		cnt    = in_frame ? l.cnt : 6'h00;
		sh     = in_frame ? l.sh : 24'h000000;
		w      = (st == DS_OPC) ? 3'h1 : qsf_lanes(l.op);
		case (w)
			3'h2: bits = {2'b00, link.line[1:0]};
			3'h4: bits = link.line;
			default: bits = {3'b000, link.line[0]};
		endcase
		nsh  = (sh << w) | {20'h00000, bits};
		ncnt = cnt + {3'b000, w};
		next_l.st  = st;
		next_l.cnt = ncnt;
		next_l.sh  = nsh;
		if (!in_frame) begin
			next_l.wbytes = 9'h000;
		end
		case (st)
			DS_OPC: begin
				if (ncnt == `QSF_OPC_BITS) begin
					op         = nsh[7:0];
					next_l.op  = op;
					next_l.cnt = 6'h00;
					if (busy_l && op != `QSF_OP_RDSR &&
						op != `QSF_OP_SUSP) begin
						next_l.st = DS_IGNORE;
					end else if (op == `QSF_OP_RDSR) begin
						next_l.st = DS_READ;
						next_l.tx = status_l;
					end else if (op == `QSF_OP_QUAD && !quad_en_l) begin
						next_l.st = DS_IGNORE;
					end else if (qsf_has_addr(op)) begin
						next_l.st = DS_ADDR;
					end else begin
						next_l.st = DS_IGNORE;
						if (qsf_bare_cmd(op)) begin
							next_l.cmd_op   = op;
							next_l.cmd_addr = 24'h000000;
							next_l.cmd_tgl  = ~l.cmd_tgl;
						end
					end
				end
			end
			DS_ADDR: begin
				if (ncnt == `QSF_ADDR_BITS) begin
					next_l.cnt      = 6'h00;
					next_l.cmd_op   = l.op;
					next_l.cmd_addr = nsh;
					next_l.cmd_tgl  = ~l.cmd_tgl;
					if (qsf_is_erase(l.op)) begin
						next_l.st = DS_IGNORE;
					end else if (l.op == `QSF_OP_PROG) begin
						next_l.st = DS_WRITE;
					end else if (qsf_dummy(l.op) == 6'h00) begin
						next_l.st = DS_READ;
						next_l.tx = rd_l;
					end else begin
						next_l.st = DS_DUMMY;
					end
				end
			end
			DS_DUMMY: begin
				next_l.cnt = cnt + 6'h01;
				if (cnt + 6'h01 == qsf_dummy(l.op)) begin
					next_l.st  = DS_READ;
					next_l.cnt = 6'h00;
					next_l.tx  = rd_l;
				end
			end
			DS_READ: begin
				next_l.tx = l.tx << w;
				if (ncnt == `QSF_BYTE_BITS) begin
					next_l.cnt = 6'h00;
					next_l.tx  = rd_l;
				end
			end
			DS_WRITE: begin
				if (ncnt == `QSF_BYTE_BITS) begin
					next_l.cnt = 6'h00;
					// bytes past one page are dropped here
					if (l.wbytes < `QSF_PAGE_BYTES) begin
						next_l.wr_data = nsh[7:0];
						next_l.wr_tgl  = ~l.wr_tgl;
						next_l.wbytes  = l.wbytes + 9'h001;
					end
				end
			end
			default: begin
				next_l.cnt = cnt;
			end
		endcase
		if (in_frame && hold_on) begin
			next_l = l;
		end
	end

	always_ff @(posedge link.sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// falling-edge launch, released asynchronously by deselect or hold
	always_comb begin
		next_o = '0;
		if (l.st == DS_READ) begin
			case (qsf_lanes(l.op))
				3'h4: begin
					next_o.d_o  = l.tx[7:4];
					next_o.d_oe = 4'hF;
				end
				3'h2: begin
					next_o.d_o  = {2'b00, l.tx[7:6]};
					next_o.d_oe = 4'h3;
				end
				default: begin
					next_o.d_o  = {2'b00, l.tx[7], 1'b0};
					next_o.d_oe = 4'h2;
				end
			endcase
		end
	end

	always_ff @(negedge link.sclk or negedge out_rst_n) begin
		if (!out_rst_n) begin
			o <= '0;
		end else begin
			o <= next_o;
		end
	end

	assign link.d_o  = o.d_o;
	assign link.d_oe = o.d_oe;

	////////////////////////////////////////////////////////////////////////
	// core side
	always_comb begin
		next_s           = s;
		next_s.cmd_valid = 1'b0;
		next_s.wr_valid  = 1'b0;
		if (ssync[3]) begin
			next_s.armed = 1'b1;
		end
		if (ssync[2] != s.cmd_seen) begin
			next_s.cmd_seen  = ssync[2];
			next_s.cmd_valid = 1'b1;
			next_s.cmd_op    = l.cmd_op;
			next_s.cmd_addr  = l.cmd_addr;
		end
		if (ssync[1] != s.wr_seen) begin
			next_s.wr_seen  = ssync[1];
			next_s.wr_valid = 1'b1;
			next_s.wr_data  = l.wr_data;
		end
		next_s.standby     = ssync[3] & ~i_busy;
		next_s.wp_asserted = ~ssync[0] & ~i_quad_lines_enable;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_cmd_valid   = s.cmd_valid;
	assign o_cmd_op      = s.cmd_op;
	assign o_cmd_addr    = s.cmd_addr;
	assign o_wr_valid    = s.wr_valid;
	assign o_wr_data     = s.wr_data;
	assign o_standby     = s.standby;
	assign o_wp_asserted = s.wp_asserted;
endmodule
`default_nettype wire

// >>> logic/qsf_host.sv
`include "qsf_consts.svh"
`default_nettype none
module qsf_host #(
	parameter int HALF = 4
) (
	qsf_if.host                  link,
	input  wire logic            i_clk_sys,
	input  wire logic            i_rst_n,
	input  wire logic            i_req_valid,
	output logic                 o_req_ready,
	input  wire qsf_pkg::qsf_byte_t i_req_op,
	input  wire qsf_pkg::qsf_addr_t i_req_addr,
	input  wire logic            i_req_write,
	input  wire logic [8:0]      i_req_len,
	input  wire qsf_pkg::qsf_byte_t i_wr_data,
	output logic                 o_wr_take,
	output logic                 o_rd_valid,
	output qsf_pkg::qsf_byte_t   o_rd_data,
	output logic                 o_done,
	input  wire logic            i_hold,
	input  wire logic            i_wp_n
);
	import qsf_pkg::*;

	localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
	localparam qsf_host_t  H_RST = '{st: HS_IDLE, cs_n: 1'b1,
		hold_n: 1'b1, default: '0};

	qsf_host_t  h;
	qsf_host_t  next_h;
	logic [3:0] rx_s;
	logic       tick;
	logic       busy;
	logic       go_data;
	logic       upd;
	logic [2:0] w;
	logic [3:0] bits;

	// read data is resynchronised, so HALF must stay at 3 or more
	qsf_sync #(
		.W(4)
	) u_rsync (
		.i_clk   (i_clk_sys),
		.i_rst_n (i_rst_n),
		.i_d     (link.line),
		.o_q     (rx_s)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_h          = h;
		next_h.wr_take  = 1'b0;
		next_h.rd_valid = 1'b0;
		next_h.done     = 1'b0;
		go_data         = 1'b0;
		upd             = 1'b0;
		busy = h.st == HS_OPC || h.st == HS_ADDR || h.st == HS_DUMMY ||
			h.st == HS_DATA;
		tick = h.div == HALF_M1;
		w    = (h.st == HS_OPC) ? 3'h1 : qsf_lanes(h.op);
		case (w)
			3'h2: bits = {2'b00, rx_s[1:0]};
			3'h4: bits = rx_s;
			default: bits = {3'b000, rx_s[1]};
		endcase
		next_h.div = tick ? 8'h00 : h.div + 8'h01;
		// hold only between bits, clock low, and never on quad lines
		// never on a rising tick, or hold and clock would move together
		if (busy && !h.sclk && !tick && i_hold &&
			qsf_lanes(h.op) != 3'h4) begin
			next_h.hold_n = 1'b0;
		end else if (!i_hold) begin
			next_h.hold_n = 1'b1;
		end
		upd = next_h.hold_n != h.hold_n;
		if (!h.hold_n) begin
			next_h.div = h.div;
		end else begin
			case (h.st)
				HS_IDLE: begin
					next_h.div = 8'h00;
					upd        = 1'b1;
					if (i_req_valid) begin
						next_h.st   = HS_SEL;
						next_h.cs_n = 1'b0;
						next_h.op   = i_req_op;
						next_h.addr = i_req_addr;
						next_h.wr   = i_req_write;
						next_h.len  = i_req_len;
						next_h.cnt  = 6'h00;
						next_h.tx   = {i_req_op, 24'h000000};
					end
				end
				HS_SEL: begin
					if (tick) begin
						next_h.st = HS_OPC;
						upd       = 1'b1;
					end
				end
				HS_DESEL: begin
					if (tick && h.sclk) begin
						next_h.sclk = 1'b0;
					end else if (tick) begin
						next_h.cs_n = 1'b1;
						next_h.done = 1'b1;
						next_h.st   = HS_IDLE;
					end
				end
				default: begin
					if (tick && h.sclk) begin
						next_h.sclk = 1'b0;
						upd         = 1'b1;
					end else if (tick) begin
						next_h.sclk = 1'b1;
						next_h.cnt  = h.cnt + {3'b000, w};
						next_h.tx   = h.tx << w;
						case (h.st)
							HS_OPC: begin
								if (next_h.cnt == `QSF_OPC_BITS) begin
									next_h.cnt = 6'h00;
									if (qsf_has_addr(h.op)) begin
										next_h.st = HS_ADDR;
										next_h.tx = {h.addr, 8'h00};
									end else begin
										go_data = 1'b1;
									end
								end
							end
							HS_ADDR: begin
								if (next_h.cnt == `QSF_ADDR_BITS) begin
									next_h.cnt = 6'h00;
									if (qsf_dummy(h.op) != 6'h00) begin
										next_h.st = HS_DUMMY;
									end else begin
										go_data = 1'b1;
									end
								end
							end
							HS_DUMMY: begin
								next_h.cnt = h.cnt + 6'h01;
								if (next_h.cnt == qsf_dummy(h.op)) begin
									go_data = 1'b1;
								end
							end
							default: begin
								next_h.rx = (h.rx << w) | {4'h0, bits};
								if (next_h.cnt == `QSF_BYTE_BITS) begin
									next_h.cnt      = 6'h00;
									next_h.bytes    = h.bytes + 9'h001;
									next_h.rd_valid = ~h.wr;
									next_h.rd_data  = next_h.rx;
									next_h.tx = {i_wr_data, 24'h000000};
									next_h.wr_take  = h.wr;
									if (next_h.bytes == h.len) begin
										next_h.st      = HS_DESEL;
										next_h.wr_take = 1'b0;
									end
								end
							end
						endcase
					end
				end
			endcase
		end
		if (go_data) begin
			next_h.cnt   = 6'h00;
			next_h.bytes = 9'h000;
			if (h.len == 9'h000) begin
				next_h.st = HS_DESEL;
			end else begin
				next_h.st      = HS_DATA;
				next_h.tx      = {i_wr_data, 24'h000000};
				next_h.wr_take = h.wr;
			end
		end
		next_h.ready = next_h.st == HS_IDLE;
		// lines move only with the clock low, ahead of the next rise
		if (upd) begin
			next_h.io_o  = {next_h.hold_n, i_wp_n, 2'b00};
			next_h.io_oe = (qsf_lanes(next_h.op) == 3'h4 &&
				next_h.st != HS_OPC && next_h.st != HS_IDLE) ?
				4'h0 : 4'hC;
			if (next_h.st == HS_OPC || next_h.st == HS_ADDR ||
				(next_h.st == HS_DATA && next_h.wr)) begin
				case ((next_h.st == HS_OPC) ? 3'h1 : qsf_lanes(next_h.op))
					3'h4: begin
						next_h.io_o  = next_h.tx[31:28];
						next_h.io_oe = 4'hF;
					end
					3'h2: begin
						next_h.io_o[1:0]  = next_h.tx[31:30];
						next_h.io_oe[1:0] = 2'b11;
					end
					default: begin
						next_h.io_o[0]  = next_h.tx[31];
						next_h.io_oe[0] = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			h <= H_RST;
		end else begin
			h <= next_h;
		end
	end

	assign link.cs_n   = h.cs_n;
	assign link.sclk   = h.sclk;
	assign link.h_o    = h.io_o;
	assign link.h_oe   = h.io_oe;
	assign o_req_ready = h.ready;
	assign o_wr_take   = h.wr_take;
	assign o_rd_valid  = h.rd_valid;
	assign o_rd_data   = h.rd_data;
	assign o_done      = h.done;
endmodule
`default_nettype wire

// >>> dv/qsf_link_props.sv
`default_nettype none
module qsf_link_props (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_quad_lines_enable,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic [3:0] h_o,
	input  wire logic [3:0] h_oe,
	input  wire logic [3:0] d_o,
	input  wire logic [3:0] d_oe,
	input  wire logic [3:0] line
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////////////////////////////////////
	property p_desel_release;
		cs_n && $past(cs_n) |-> d_oe == 4'h0;
	endproperty
	a_desel_release: assert property (p_desel_release)
		else $error("device drives a line while deselected");
	// host leaves line 1 alone, so only the pull-up may show there
	property p_idle_pullup;
		cs_n && $past(cs_n) |-> line[1];
	endproperty
	a_idle_pullup: assert property (p_idle_pullup)
		else $error("data line 1 not at idle level while deselected");
	property p_upper_quiet;
		!i_quad_lines_enable && $past(!i_quad_lines_enable)
			|-> d_oe[3:2] == 2'h0;
	endproperty
	a_upper_quiet: assert property (p_upper_quiet)
		else $error("upper data lines driven with quad lines off");
	property p_fall_launch;
		!cs_n && $past(!cs_n) && $changed(d_o) |-> $fell(sclk);
	endproperty
	a_fall_launch: assert property (p_fall_launch)
		else $error("device output moved away from a falling clock");
	property p_hold_release;
		!i_quad_lines_enable && !cs_n && !line[3] |-> d_oe == 4'h0;
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("device drives a line during hold");
	property p_hold_enter;
		!i_quad_lines_enable && !cs_n && $fell(line[3]) |-> !sclk;
	endproperty
	a_hold_enter: assert property (p_hold_enter)
		else $error("hold entered with clock high");
	property p_hold_exit;
		!i_quad_lines_enable && !cs_n && $rose(line[3]) |-> !sclk;
	endproperty
	a_hold_exit: assert property (p_hold_exit)
		else $error("hold left with clock high");
	property p_mode0_frame;
		$changed(cs_n) |-> !sclk && $past(!sclk);
	endproperty
	a_mode0_frame: assert property (p_mode0_frame)
		else $error("chip select moved with clock not idle low");
	property p_lane_sets;
		d_oe != 4'h0 |-> d_oe inside {4'h2, 4'h3, 4'hF};
	endproperty
	a_lane_sets: assert property (p_lane_sets)
		else $error("device drives an odd set of lines");
	property p_quad_gate;
		d_oe == 4'hF |-> i_quad_lines_enable;
	endproperty
	a_quad_gate: assert property (p_quad_gate)
		else $error("four lines driven without quad lines enable");
endmodule
`default_nettype wire

// >>> dv/tb.sv
`include "qsf_consts.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import qsf_pkg::*;

	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b1;
	logic       req_valid = 1'b0;
	logic       req_ready;
	qsf_byte_t  req_op = 8'h00;
	qsf_addr_t  req_addr = 24'h000000;
	logic       req_write = 1'b0;
	logic [8:0] req_len = 9'h000;
	qsf_byte_t  wr_data = 8'h00;
	logic       wr_take, rd_valid, done, cmd_valid, wr_valid;
	qsf_byte_t  rd_data, cmd_op, wr_out;
	qsf_addr_t  cmd_addr;
	logic       hold = 1'b0;
	logic       wp_n = 1'b1;
	logic       quad = 1'b0;
	logic       busy = 1'b0;
	qsf_byte_t  status = 8'h3C;
	qsf_byte_t  rd_src = 8'hA5;
	logic       standby, wp_asserted;
	logic [31:0] cmd_q[$];
	qsf_byte_t  wr_q[$], rd_q[$];
	int         n_fail = 0;
	int         cmp_count = 0;
	qsf_byte_t  ers[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
	qsf_byte_t  rds[3] = '{8'h03, 8'h0B, 8'hBB};

	always #2 clk_sys = ~clk_sys;

	qsf_if lnk ();
	qsf_host #(.HALF(4)) i_qsf_host (.link(lnk), .i_clk_sys(clk_sys),
		.i_rst_n(rst_n), .i_req_valid(req_valid), .o_req_ready(req_ready),
		.i_req_op(req_op), .i_req_addr(req_addr), .i_req_write(req_write),
		.i_req_len(req_len), .i_wr_data(wr_data), .o_wr_take(wr_take),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_done(done),
		.i_hold(hold), .i_wp_n(wp_n));
	qsf_dev i_qsf_dev (.link(lnk), .i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_quad_lines_enable(quad), .i_busy(busy), .i_status(status),
		.i_rd_data(rd_src), .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op),
		.o_cmd_addr(cmd_addr), .o_wr_valid(wr_valid), .o_wr_data(wr_out),
		.o_standby(standby), .o_wp_asserted(wp_asserted));
	qsf_link_props i_qsf_link_props (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_quad_lines_enable(quad), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
		.h_o(lnk.h_o), .h_oe(lnk.h_oe), .d_o(lnk.d_o), .d_oe(lnk.d_oe),
		.line(lnk.line));

	////////////////////////////////////////////////////////////////////////
	// collect every report; next program byte follows each take
	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1) cmd_q.push_back({cmd_op, cmd_addr});
		if (wr_valid === 1'b1) wr_q.push_back(wr_out);
		if (rd_valid === 1'b1) rd_q.push_back(rd_data);
		if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
	end

	task automatic check(input string w, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic exp_cmd(input logic [31:0] e);
		logic [31:0] v;
		v = 32'hXXXXXXXX;
		if (cmd_q.size() > 0) v = cmd_q.pop_front();
		check("cmd", v, e);
	endtask

	task automatic exp_q(input string w, ref qsf_byte_t q[$], input int n,
		input qsf_byte_t b, input qsf_byte_t st);
		check(w, q.size(), n);
		foreach (q[k]) check(w, q[k], qsf_byte_t'(b + st * k));
		q.delete();
	endtask

	// one frame through the host user port, bounded waits only
	task automatic xfer(input qsf_byte_t op, input qsf_addr_t a,
		input logic w, input logic [8:0] n);
		int k;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_write <= w;
		req_len <= n;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (req_ready !== 1'b1 && k < 100);
		req_valid <= 1'b0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (done !== 1'b1 && k < 20000);
		check("done", done, 1'b1);
		// reports cross into the system clock a few cycles late
		repeat (12) @(posedge clk_sys);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end

	initial begin
		// a real falling edge, so the link-clocked flops reset too
		rst_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		check("standby", standby, 1'b1);
		xfer(`QSF_OP_WREN, 24'h000000, 1'b0, 9'h000);
		exp_cmd({8'h06, 24'h000000});
		for (int i = 0; i < 5; i++) begin
			xfer(ers[i], 24'h123456, 1'b0, 9'h000);
			exp_cmd({ers[i], (i < 3) ? 24'h123456 : 24'h000000});
		end
		wr_data <= 8'h5A;
		xfer(`QSF_OP_PROG, 24'hABCDEF, 1'b1, 9'h101);
		exp_cmd({8'h02, 24'hABCDEF});
		exp_q("wr", wr_q, 256, 8'h5A, 8'h01);
		for (int i = 0; i < 3; i++) begin
			xfer(rds[i], 24'h000100, 1'b0, 9'h002);
			exp_cmd({rds[i], 24'h000100});
			exp_q("rd", rd_q, 2, 8'hA5, 8'h00);
		end
		// quad read is refused until quad lines are enabled
		xfer(`QSF_OP_QUAD, 24'h000100, 1'b0, 9'h002);
		check("refused", cmd_q.size(), 0);
		rd_q.delete();
		quad <= 1'b1;
		xfer(`QSF_OP_QUAD, 24'h000200, 1'b0, 9'h002);
		exp_cmd({8'hEB, 24'h000200});
		exp_q("quad rd", rd_q, 2, 8'hA5, 8'h00);
		wp_n <= 1'b0;
		repeat (12) @(posedge clk_sys);
		check("wp quad", wp_asserted, 1'b0);
		quad <= 1'b0;
		repeat (12) @(posedge clk_sys);
		check("wp", wp_asserted, 1'b1);
		wp_n <= 1'b1;
		// pause in mid-address; the bit count must survive it
		fork
			xfer(`QSF_OP_READ, 24'h000300, 1'b0, 9'h003);
			begin
				repeat (200) @(posedge clk_sys);
				hold <= 1'b1;
				repeat (80) @(posedge clk_sys);
				hold <= 1'b0;
			end
		join
		exp_cmd({8'h03, 24'h000300});
		exp_q("hold rd", rd_q, 3, 8'hA5, 8'h00);
		busy <= 1'b1;
		repeat (12) @(posedge clk_sys);
		check("standby busy", standby, 1'b0);
		xfer(`QSF_OP_WREN, 24'h000000, 1'b0, 9'h000);
		check("busy refused", cmd_q.size(), 0);
		xfer(`QSF_OP_RDSR, 24'h000000, 1'b0, 9'h001);
		exp_q("status", rd_q, 1, 8'h3C, 8'h00);
		cmd_q.delete();
		xfer(`QSF_OP_SUSP, 24'h000000, 1'b0, 9'h000);
		exp_cmd({8'h75, 24'h000000});
		busy <= 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
